// file: sfpi_host_model.sv
// sfpi_host_model: spi host that drives select, serial clock and data lanes.
// assumes: the bench resolves the lanes and feeds them back on io_in.
`timescale 1ns/1ns
`default_nettype none
module sfpi_host_model (
   input  wire logic       clk_in,
   input  wire logic [3:0] io_in,
   output var logic        sel_n_out,
   output var logic        sck_out,
   output var logic [3:0]  val_out,
   output var logic [3:0]  drv_out
);
   // ********************************
   // bus tasks
   // ********************************
   // four core cycles per half period keeps sck below core/4
   localparam int HALF = 4;

   initial begin
      sel_n_out = 1'b1;
      sck_out   = 1'b0;
      val_out   = 4'hF;
      drv_out   = 4'h0;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic start(input logic idle_hi);
      sck_out = idle_hi;
      step(HALF);
      sel_n_out = 1'b0;
      step(HALF);
   endtask

   task automatic stop();
      sck_out = 1'b0;
      step(HALF);
      sel_n_out = 1'b1;
      drv_out = 4'h0;
      step(HALF);
   endtask

   // n steps of one lane if w is 1, else four lanes, msb first; data set while sck is low
   task automatic send(input logic [7:0] d, input int w, input int n);
      for (int i = 0; i < n; i++) begin
         sck_out = 1'b0;
         if (w == 1) val_out[0] = d[7-i];
         else val_out = d[7-4*i -: 4];
         drv_out = (w == 1) ? 4'h1 : 4'hF;
         step(HALF);
         sck_out = 1'b1;
         step(HALF);
      end
   endtask

   task automatic recv(input int w, output logic [7:0] d);
      d = 8'h00;
      drv_out = 4'h0;
      for (int i = 0; i < 8 / w; i++) begin
         sck_out = 1'b0;
         step(HALF);
         sck_out = 1'b1;
         if (w == 1) d = {d[6:0], io_in[1]};
         else if (w == 2) d = {d[5:0], io_in[1:0]};
         else d = {d[3:0], io_in};
         step(HALF);
      end
   endtask

   // pin changes only with sck low, as hold entry and exit need
   task automatic pin(input int k, input logic v, input logic en);
      sck_out = 1'b0;
      step(HALF);
      val_out[k] = v;
      drv_out[k] = en;
      step(HALF);
   endtask

   task automatic wiggle(input int n);
      for (int i = 0; i < n; i++) begin
         sck_out = 1'b1;
         val_out[0] = ~val_out[0];
         step(2);
         sck_out = 1'b0;
         step(2);
      end
   endtask
endmodule
`default_nettype wire

// file: sfpi_pkg.sv
// sfpi_pkg: constants and carrier types for the serial flash pin front end.
// assumes: all pins are sampled synchronously to the 20 MHz core clock.
package sfpi_pkg;

   // ********************************
   // lane modes and widths
   // ********************************
   typedef enum logic [1:0] {
      SFPI_LANE_SINGLE,
      SFPI_LANE_DUAL,
      SFPI_LANE_QUAD
   } sfpi_lane_t;

   localparam int unsigned BIT_CNT_W              = 3;
   localparam logic [2:0]  BIT_CNT_RST            = 3'h0;
   localparam logic [7:0]  BYTE_RST               = 8'h00;
   localparam logic [1:0]  LOCK_SEL_PIN_PROTECT   = 2'h1;
   localparam int unsigned CLK_PERIOD_NS          = 50;

   // ********************************
   // pin carriers
   // ********************************
   typedef struct packed {
      logic sel_n;
      logic sck;
      logic [3:0] io;
      logic [3:0] io_pulled;
   } sfpi_pins_in_t;

   typedef struct packed {
      logic [3:0] dout;
      logic [3:0] oe;
   } sfpi_pins_out_t;

endpackage

// file: sfpi_top.sv
// sfpi_top: pin-side front end of a serial flash (select, clock, lanes, hold).
// assumes: the host is an spi controller in mode 0 or 3; all pins are
// sampled by CORE_CLK_IN, which must run well above the serial clock.
//
// Contract
// - select falling edge starts new command
// - select rising edge ends current command
// - standby waits for internal busy cycle end
// - input bits sampled on clock rising edge
// - output changes on clock falling edge
// - input ignored while deselected
// - output high impedance while deselected
// - dual/quad reads turn lanes into outputs
// - pin protect refuses status write when low
// - quad enable makes protect pin third lane
// - quad disabled makes fourth pin hold
// - quad enable makes hold pin fourth lane
// - hold keeps bit position
// - hold ignored while deselected
// - hold entered on falling edge, clock low
// - hold left on rising edge, clock low
// - undriven protect/hold read as high
// - continuous quad read skips opcode
// - four-wire bus, device is target
`timescale 1ns/1ns
`default_nettype none
module sfpi_top (
   input  wire logic       CORE_CLK_IN,
   input  wire logic       RESETN_IN,
   input  wire logic       CLK_EN_IN,
   input  wire logic       SEL_N_IN,
   input  wire logic       SCK_IN,
   input  wire logic [3:0] IO_IN,
   input  wire logic [3:0] IO_DRIVEN_IN,
   output logic      [3:0] IO_OUT,
   output logic      [3:0] IO_OE_OUT,
   input  wire logic       QUAD_LANE_ENABLE_BIT_IN,
   input  wire logic       STATUS_LOCK_SELECT_HIGH_IN,
   input  wire logic       STATUS_LOCK_SELECT_LOW_IN,
   input  wire logic       BUSY_IN,
   input  wire logic [1:0] READ_LANES_IN,
   input  wire logic       READ_DATA_PHASE_IN,
   input  wire logic       CONT_READ_ARM_IN,
   input  wire logic [7:0] TX_BYTE_IN,
   output logic            TX_BYTE_TAKE_OUT,
   output logic [7:0]      RX_BYTE_OUT,
   output logic            RX_VALID_OUT,
   output logic            RX_QUAD_ADDR_OUT,
   output logic            CMD_START_OUT,
   output logic            CMD_END_OUT,
   output logic            STANDBY_OUT,
   output logic            HOLD_ACTIVE_OUT,
   output logic            STATUS_WRITE_ALLOWED_OUT
);

   // ********************************
   // input conditioning
   // ********************************
   logic       sel_d_reg;
   logic       sck_d_reg;
   logic       hold_d_reg;
   logic [3:0] io_eff;
   logic       selected;
   logic       sck_rise;
   logic       sck_fall;
   logic       hold_pin;
   logic       hold_reg;
   logic       cont_reg;
   logic       first_byte_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic [3:0] dout_reg;
   logic       out_en_reg;
   logic       standby_reg;
   logic       quad_mode;
   logic [2:0] step;
   logic [2:0] tx_cnt_reg;

   // ********************************
   // helpers
   // ********************************
   // leading bits of a byte for one step of w lanes, right aligned
   function automatic logic [3:0] lead_bits(input logic [7:0] b, input logic [2:0] w);
      logic [3:0] r;
      if (w == 3'h4) begin
         r = b[7:4];
      end else if (w == 3'h2) begin
         r = {2'h0, b[7:6]};
      end else begin
         r = {3'h0, b[7]};
      end
      return r;
   endfunction

   // shift four new lane bits if w is 4, else one, into the low end of a byte
   function automatic logic [7:0] shift_in(input logic [7:0] s, input logic [3:0] io,
                                           input logic [2:0] w);
      logic [7:0] r;
      if (w == 3'h4) begin
         r = {s[3:0], io};
      end else begin
         r = {s[6:0], io[0]};
      end
      return r;
   endfunction

   // undriven protect and hold lanes float high via internal pull-up
   always_comb begin
      io_eff    = IO_IN;
      io_eff[2] = IO_DRIVEN_IN[2] ? IO_IN[2] : 1'b1;
      io_eff[3] = IO_DRIVEN_IN[3] ? IO_IN[3] : 1'b1;
   end

   assign selected  = !SEL_N_IN;
   assign hold_pin  = !QUAD_LANE_ENABLE_BIT_IN && !io_eff[3];
   assign quad_mode = QUAD_LANE_ENABLE_BIT_IN && (READ_LANES_IN == 2'h2);
   // edges are seen only when selected and not held; the mode 3 idle-high
   // clock gives no rising edge before the first real bit
   assign sck_rise  = selected && !hold_reg && SCK_IN && !sck_d_reg;
   assign sck_fall  = selected && !hold_reg && !SCK_IN && sck_d_reg;

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESETN_IN) begin
         sel_d_reg  <= 1'b1;
         sck_d_reg  <= 1'b0;
         hold_d_reg <= 1'b0;
      end else if (CLK_EN_IN) begin
         sel_d_reg  <= SEL_N_IN;
         sck_d_reg  <= SCK_IN;
         hold_d_reg <= hold_pin;
      end
   end

   // ********************************
   // framing
   // ********************************
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESETN_IN) begin
         CMD_START_OUT <= 1'b0;
         CMD_END_OUT   <= 1'b0;
      end else if (CLK_EN_IN) begin
         CMD_START_OUT <= sel_d_reg && !SEL_N_IN;
         CMD_END_OUT   <= !sel_d_reg && SEL_N_IN;
      end
   end

   // standby follows deselect but waits out a busy internal cycle
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESETN_IN) begin
         standby_reg <= 1'b1;
      end else if (CLK_EN_IN) begin
         standby_reg <= SEL_N_IN && !BUSY_IN;
      end
   end
   assign STANDBY_OUT = standby_reg;

   // ********************************
   // hold
   // ********************************
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESETN_IN) begin
         hold_reg <= 1'b0;
      end else if (CLK_EN_IN) begin
         if (!selected) begin
            hold_reg <= 1'b0;
         end else if (!SCK_IN && hold_pin && !hold_d_reg) begin
            hold_reg <= 1'b1;
         end else if (!SCK_IN && !hold_pin && hold_d_reg) begin
            hold_reg <= 1'b0;
         end
      end
   end
   assign HOLD_ACTIVE_OUT = hold_reg;

   // ********************************
   // receive path
   // ********************************
   // continuous quad read: next frame opens straight with quad address
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESETN_IN) begin
         cont_reg <= 1'b0;
      end else if (CLK_EN_IN) begin
         if (CMD_END_OUT) begin
            cont_reg <= CONT_READ_ARM_IN && QUAD_LANE_ENABLE_BIT_IN;
         end
      end
   end

   always_comb begin
      if (READ_DATA_PHASE_IN && READ_LANES_IN == 2'h2 && QUAD_LANE_ENABLE_BIT_IN) begin
         step = 3'h4;
      end else if (READ_DATA_PHASE_IN && READ_LANES_IN == 2'h1) begin
         step = 3'h2;
      end else if (first_byte_reg && cont_reg) begin
         step = 3'h4;
      end else begin
         step = 3'h1;
      end
   end

   // bit counter is only cleared at frame start, so hold never loses place
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESETN_IN) begin
         bit_cnt_reg    <= sfpi_pkg::BIT_CNT_RST;
         shift_reg      <= sfpi_pkg::BYTE_RST;
         RX_BYTE_OUT    <= sfpi_pkg::BYTE_RST;
         RX_VALID_OUT   <= 1'b0;
         RX_QUAD_ADDR_OUT <= 1'b0;
         first_byte_reg <= 1'b0;
      end else if (CLK_EN_IN) begin
         RX_VALID_OUT <= 1'b0;
         if (sel_d_reg && !SEL_N_IN) begin
            bit_cnt_reg    <= sfpi_pkg::BIT_CNT_RST;
            first_byte_reg <= 1'b1;
         end else if (sck_rise && !READ_DATA_PHASE_IN) begin
            shift_reg <= shift_in(shift_reg, io_eff, step);
            bit_cnt_reg <= bit_cnt_reg + step;
            if (3'(bit_cnt_reg + step) == 3'h0) begin
               RX_BYTE_OUT      <= shift_in(shift_reg, io_eff, step);
               RX_VALID_OUT     <= 1'b1;
               RX_QUAD_ADDR_OUT <= first_byte_reg && cont_reg;
               first_byte_reg   <= 1'b0;
            end
         end
      end
   end

   // ********************************
   // transmit path
   // ********************************
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESETN_IN) begin
         tx_reg     <= sfpi_pkg::BYTE_RST;
         tx_cnt_reg <= sfpi_pkg::BIT_CNT_RST;
         dout_reg   <= 4'h0;
         out_en_reg <= 1'b0;
         TX_BYTE_TAKE_OUT <= 1'b0;
      end else if (CLK_EN_IN) begin
         TX_BYTE_TAKE_OUT <= 1'b0;
         // own bit count: the receive counter stands still in the output phase
         if (!selected || !READ_DATA_PHASE_IN) begin
            out_en_reg <= 1'b0;
            tx_cnt_reg <= sfpi_pkg::BIT_CNT_RST;
         end else if (sck_fall) begin
            out_en_reg <= 1'b1;
            tx_cnt_reg <= tx_cnt_reg + step;
            if (tx_cnt_reg == 3'h0) begin
               tx_reg           <= TX_BYTE_IN << step;
               TX_BYTE_TAKE_OUT <= 1'b1;
               dout_reg         <= lead_bits(TX_BYTE_IN, step);
            end else begin
               tx_reg   <= tx_reg << step;
               dout_reg <= lead_bits(tx_reg, step);
            end
         end
      end
   end

   // lane output mapping; single mode drives the serial output lane only
   always_comb begin
      IO_OUT    = 4'h0;
      IO_OE_OUT = 4'h0;
      if (out_en_reg && !hold_reg && selected) begin
         case (READ_LANES_IN)
            2'h2: begin
               IO_OUT    = dout_reg;
               IO_OE_OUT = quad_mode ? 4'hF : 4'h0;
            end
            2'h1: begin
               IO_OUT    = {2'h0, dout_reg[1:0]};
               IO_OE_OUT = 4'h3;
            end
            default: begin
               IO_OUT    = {2'h0, dout_reg[0], 1'b0};
               IO_OE_OUT = 4'h2;
            end
         endcase
      end
   end

   // ********************************
   // status write protection
   // ********************************
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESETN_IN) begin
         STATUS_WRITE_ALLOWED_OUT <= 1'b1;
      end else if (CLK_EN_IN) begin
         STATUS_WRITE_ALLOWED_OUT <= !(!QUAD_LANE_ENABLE_BIT_IN
            && {STATUS_LOCK_SELECT_HIGH_IN, STATUS_LOCK_SELECT_LOW_IN}
               == sfpi_pkg::LOCK_SEL_PIN_PROTECT
            && !io_eff[2]);
      end
   end

   // ********************************
   // checks
   // ********************************
   deselect_float_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      SEL_N_IN |=> IO_OE_OUT == 4'h0)
      else $error("lanes driven while deselected");
   hold_float_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      hold_reg |-> IO_OE_OUT == 4'h0)
      else $error("lanes driven during hold");
   hold_desel_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      CLK_EN_IN && SEL_N_IN |=> !hold_reg)
      else $error("hold active while deselected");
   hold_enter_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      $rose(hold_reg) |-> !$past(SCK_IN))
      else $error("hold entered with clock high");
   hold_leave_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      $fell(hold_reg) && !$past(SEL_N_IN) |-> !$past(SCK_IN))
      else $error("hold left with clock high");
   start_pulse_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      CLK_EN_IN && sel_d_reg && !SEL_N_IN |=> CMD_START_OUT)
      else $error("frame start missed");
   end_pulse_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      CLK_EN_IN && !sel_d_reg && SEL_N_IN |=> CMD_END_OUT)
      else $error("frame end missed");
   standby_busy_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      CLK_EN_IN && BUSY_IN |=> !STANDBY_OUT)
      else $error("standby while busy");
   hold_count_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      hold_reg && $past(hold_reg) |-> $stable(bit_cnt_reg))
      else $error("bit position moved during hold");
   protect_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      CLK_EN_IN && !QUAD_LANE_ENABLE_BIT_IN && !STATUS_LOCK_SELECT_HIGH_IN
      && STATUS_LOCK_SELECT_LOW_IN && IO_DRIVEN_IN[2] && !IO_IN[2]
      |=> !STATUS_WRITE_ALLOWED_OUT)
      else $error("status write not refused");
   take_on_fall_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      TX_BYTE_TAKE_OUT && $past(CLK_EN_IN) |-> $past(sck_fall))
      else $error("output byte taken off a clock fall");
   rx_on_rise_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      RX_VALID_OUT && $past(CLK_EN_IN) |-> $past(sck_rise))
      else $error("byte completed off a clock rise");
   rx_desel_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      CLK_EN_IN && SEL_N_IN |=> !RX_VALID_OUT)
      else $error("byte received while deselected");
   quad_oe_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      IO_OE_OUT[3] |-> QUAD_LANE_ENABLE_BIT_IN)
      else $error("quad lanes driven with quad disabled");
   standby_sel_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      CLK_EN_IN && !SEL_N_IN |=> !STANDBY_OUT)
      else $error("standby while selected");

endmodule
`default_nettype wire

// file: tb_sfpi_top.sv
// tb_sfpi_top: self-checking bench for the serial flash pin front end.
// assumes: sfpi_host_model plays the host; lane levels are resolved here.
`timescale 1ns/1ns
`default_nettype none
module tb_sfpi_top;
   logic            CORE_CLK_IN, RESETN_IN, CLK_EN_IN, BUSY_IN, CONT_READ_ARM_IN;
   logic            QUAD_LANE_ENABLE_BIT_IN, READ_DATA_PHASE_IN;
   logic            STATUS_LOCK_SELECT_HIGH_IN, STATUS_LOCK_SELECT_LOW_IN;
   logic [1:0]      READ_LANES_IN;
   logic [7:0]      TX_BYTE_IN, RX_BYTE_OUT;
   logic [3:0]      IO_OUT, IO_OE_OUT;
   logic            TX_BYTE_TAKE_OUT, RX_VALID_OUT, RX_QUAD_ADDR_OUT;
   logic            CMD_START_OUT, CMD_END_OUT, STANDBY_OUT, HOLD_ACTIVE_OUT;
   logic            STATUS_WRITE_ALLOWED_OUT;
   wire logic       SEL_N_IN, SCK_IN;
   wire logic [3:0] IO_IN, IO_DRIVEN_IN, hval, hdrv;
   logic [8:0]      rx_q[$];
   int              mismatches, n_checks, n_start, n_end, n_take, cycles;

   // ********************************
   // wiring
   // ********************************
   sfpi_top dut (
      .CORE_CLK_IN, .RESETN_IN, .CLK_EN_IN, .SEL_N_IN, .SCK_IN, .IO_IN, .IO_DRIVEN_IN,
      .IO_OUT, .IO_OE_OUT, .QUAD_LANE_ENABLE_BIT_IN, .STATUS_LOCK_SELECT_HIGH_IN,
      .STATUS_LOCK_SELECT_LOW_IN, .BUSY_IN, .READ_LANES_IN, .READ_DATA_PHASE_IN,
      .CONT_READ_ARM_IN, .TX_BYTE_IN, .TX_BYTE_TAKE_OUT, .RX_BYTE_OUT, .RX_VALID_OUT,
      .RX_QUAD_ADDR_OUT, .CMD_START_OUT, .CMD_END_OUT, .STANDBY_OUT, .HOLD_ACTIVE_OUT,
      .STATUS_WRITE_ALLOWED_OUT
   );
   sfpi_host_model host (.clk_in(CORE_CLK_IN), .io_in(IO_IN), .sel_n_out(SEL_N_IN),
      .sck_out(SCK_IN), .val_out(hval), .drv_out(hdrv));

   // lanes 2 and 3 are pulled high; floating 0 and 1 show the inverse of the last value
   for (genvar g = 0; g < 4; g++) begin : g_lane
      assign IO_IN[g] = IO_OE_OUT[g] ? IO_OUT[g] : hdrv[g] ? hval[g] : (g > 1) ? 1'b1 : ~hval[g];
   end
   assign IO_DRIVEN_IN = hdrv | IO_OE_OUT;

   initial CORE_CLK_IN = 1'b0;
   always #25 CORE_CLK_IN = ~CORE_CLK_IN;

   // ********************************
   // monitor and checks
   // ********************************
   // falling edge: registered outputs have settled by then
   always @(negedge CORE_CLK_IN) begin
      cycles++;
      if (RX_VALID_OUT === 1'b1) rx_q.push_back({RX_QUAD_ADDR_OUT, RX_BYTE_OUT});
      if (CMD_START_OUT === 1'b1) n_start++;
      if (CMD_END_OUT === 1'b1) n_end++;
      if (TX_BYTE_TAKE_OUT === 1'b1) n_take++;
      if (cycles == 20000) begin
         mismatches++;
         give_verdict();
      end
   end

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic rx(input logic [8:0] exp);
      logic [8:0] v;
      v = 'x;
      if (rx_q.size() > 0) v = rx_q.pop_front();
      chk(v, exp);
   endtask

   task automatic give_verdict();
      if (mismatches == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ********************************
   // tests
   // ********************************
   initial begin
      logic [7:0] d;
      RESETN_IN = 1'b0;
      CLK_EN_IN = 1'b1;
      {BUSY_IN, CONT_READ_ARM_IN, QUAD_LANE_ENABLE_BIT_IN, READ_DATA_PHASE_IN} = '0;
      {STATUS_LOCK_SELECT_HIGH_IN, STATUS_LOCK_SELECT_LOW_IN} = '0;
      READ_LANES_IN = 2'h0;
      TX_BYTE_IN = 8'h00;
      repeat (6) @(posedge CORE_CLK_IN);
      #1;
      RESETN_IN = 1'b1;
      host.step(2);
      host.start(1'b0);
      host.send(8'hA5, 1, 8);
      host.stop();
      rx(9'h0A5);
      chk(9'(n_start), 9'h001);
      chk(9'(n_end), 9'h001);
      chk(STANDBY_OUT, 1'b1);
      BUSY_IN = 1'b1;
      host.start(1'b1);
      host.send(8'h3C, 1, 8);
      host.stop();
      rx(9'h03C);
      chk(STANDBY_OUT, 1'b0);
      BUSY_IN = 1'b0;
      host.step(3);
      chk(STANDBY_OUT, 1'b1);
      host.wiggle(8);
      host.pin(3, 1'b0, 1'b1);
      chk(9'(rx_q.size()), 9'h000);
      chk(IO_OE_OUT, 4'h0);
      chk(HOLD_ACTIVE_OUT, 1'b0);
      host.pin(3, 1'b1, 1'b0);
      host.start(1'b0);
      host.send(8'h96, 1, 4);
      host.pin(3, 1'b0, 1'b1);
      chk(HOLD_ACTIVE_OUT, 1'b1);
      host.wiggle(3);
      chk(IO_OE_OUT, 4'h0);
      host.pin(3, 1'b1, 1'b0);
      chk(HOLD_ACTIVE_OUT, 1'b0);
      host.send(8'h60, 1, 4);
      host.stop();
      rx(9'h096);
      host.start(1'b0);
      host.send(8'hE1, 1, 4);
      CLK_EN_IN = 1'b0;
      host.wiggle(3);
      CLK_EN_IN = 1'b1;
      host.send(8'h10, 1, 4);
      host.stop();
      rx(9'h0E1);
      for (int k = 0; k < 16; k++) begin
         {QUAD_LANE_ENABLE_BIT_IN, STATUS_LOCK_SELECT_HIGH_IN, STATUS_LOCK_SELECT_LOW_IN} = k[3:1];
         host.pin(2, 1'b0, !k[0] && !k[3]);
         chk(STATUS_WRITE_ALLOWED_OUT, !(k[3:1] == 3'h1 && !k[0]));
      end
      host.pin(2, 1'b1, 1'b0);
      QUAD_LANE_ENABLE_BIT_IN = 1'b1;
      READ_DATA_PHASE_IN = 1'b1;
      for (int k = 0; k < 3; k++) begin
         READ_LANES_IN = 2'(k);
         TX_BYTE_IN = 8'hC0 | 8'(k + 2);
         host.start(1'b1);
         host.recv(1 << k, d);
         chk(d, TX_BYTE_IN);
         chk(IO_OE_OUT, (k == 0) ? 4'h2 : (k == 1) ? 4'h3 : 4'hF);
         chk(HOLD_ACTIVE_OUT, 1'b0);
         host.stop();
      end
      READ_DATA_PHASE_IN = 1'b0;
      chk(9'(n_take > 0), 9'h001);
      CONT_READ_ARM_IN = 1'b1;
      host.start(1'b0);
      host.send(8'h5A, 1, 8);
      host.stop();
      CONT_READ_ARM_IN = 1'b0;
      host.start(1'b0);
      host.send(8'hC3, 4, 2);
      host.stop();
      rx(9'h05A);
      rx(9'h1C3);
      host.start(1'b0);
      host.send(8'hFF, 1, 4);
      RESETN_IN = 1'b0;
      host.step(2);
      RESETN_IN = 1'b1;
      host.send(8'h81, 1, 8);
      host.stop();
      rx(9'h081);
      give_verdict();
   end
endmodule
`default_nettype wire
